//--- include/flash_aux_pkg.sv
package flash_aux_pkg;

  // ************************************************************
  // Pin and command constants
  // ************************************************************
  localparam int          ADDR_W          = 19;
  localparam int          DATA_W          = 8;
  localparam logic [18:0] UNLOCK_ADDR1    = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR2    = 19'h02aaa;
  localparam logic [7:0]  UNLOCK_DATA1    = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2    = 8'h55;
  localparam logic [7:0]  RESET_CMD       = 8'hf0;
  localparam logic [7:0]  READ_IDENTITY_CMD = 8'h90;
  // The sleep opcode is not fixed here; a plain default is used.
  localparam logic [7:0]  SLEEP_CMD       = 8'hc0;
  localparam logic [18:0] ID_MAKER_OFS    = 19'h00000;
  localparam logic [18:0] ID_PART_OFS     = 19'h00001;
  localparam logic [18:0] ID_LOCK_OFS     = 19'h00002;
  localparam int          BLOCK_SHIFT     = 16;
  localparam logic [7:0]  LOCK_SET        = 8'h01;
  localparam logic [7:0]  LOCK_CLEAR      = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 100;
  localparam int RESET_WAIT_US   = 5;
  localparam int RESET_WAIT_CYC  = RESET_WAIT_US * CLK_MHZ;
  localparam int STROBE_CYC      = 6;  // 60 ns low, covers 50 ns min.
  localparam int READ_CYC        = 21; // 210 ns covers 200 ns access.
  localparam int CNT_W           = 10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    OP_ARRAY_READ = 3'h0,
    OP_RESET      = 3'h1,
    OP_IDENTITY   = 3'h2,
    OP_MAKER      = 3'h3,
    OP_PART       = 3'h4,
    OP_LOCK       = 3'h5,
    OP_SLEEP      = 3'h6
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [18:0] addr;
    logic        with_unlock;
  } req_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
    logic        we;
  } bus_cycle_t;

endpackage : flash_aux_pkg

//--- rtl/flash_bus_cycle.sv
`timescale 1ns/1ps
module flash_bus_cycle (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     clk_en,
  input  wire flash_aux_pkg::bus_cycle_t cyc,
  input  wire logic                     cyc_valid,
  output logic                          cyc_ready,
  output logic                          cyc_done,
  output logic [7:0]                    rd_data,
  output logic [18:0]                   addr_out,
  output logic [7:0]                    dq_out,
  output logic                          dq_oe,
  input  wire logic [7:0]               dq_in,
  output logic                          chip_en_n,
  output logic                          out_en_n,
  output logic                          write_en_n
);
  import flash_aux_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_LOW  = 2'b01,
    C_HIGH = 2'b11
  } cyc_state_t;

  cyc_state_t       st_r;
  cyc_state_t       st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic             we_r;
  wire              cnt_zero = (cnt_r == '0);

  assign cyc_ready = (st_r == C_IDLE);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      C_IDLE:  if (cyc_valid) st_nxt = C_LOW;
      C_LOW:   if (cnt_zero) st_nxt = C_HIGH;
      C_HIGH:  st_nxt = C_IDLE;
      default: st_nxt = C_IDLE;
    endcase
  end

  // Address is driven on the same clock edge as the strobe falls and held until it rises,
  // so the device sees it on the fall and data on the rise.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r       <= C_IDLE;
      cnt_r      <= '0;
      we_r       <= 1'b0;
      addr_out   <= '0;
      dq_out     <= '0;
      dq_oe      <= 1'b0;
      chip_en_n  <= 1'b1;
      out_en_n   <= 1'b1;
      write_en_n <= 1'b1;
      rd_data    <= '0;
      cyc_done   <= 1'b0;
    end else if (clk_en) begin
      st_r     <= st_nxt;
      cyc_done <= 1'b0;
      case (st_r)
        C_IDLE: if (cyc_valid) begin
          we_r       <= cyc.we;
          addr_out   <= cyc.addr;
          dq_out     <= cyc.data;
          dq_oe      <= cyc.we;
          chip_en_n  <= 1'b0;
          write_en_n <= ~cyc.we;
          out_en_n   <= cyc.we;
          cnt_r      <= cyc.we ? CNT_W'(STROBE_CYC - 1)
                               : CNT_W'(READ_CYC - 1);
        end
        C_LOW: if (cnt_zero) begin
          if (!we_r) rd_data <= dq_in;
          write_en_n <= 1'b1;
          out_en_n   <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
        C_HIGH: begin
          chip_en_n <= 1'b1;
          dq_oe     <= 1'b0;
          cyc_done  <= 1'b1;
        end
        default: ;
      endcase
    end
  end

endmodule : flash_bus_cycle

//--- rtl/flash_aux_host.sv
`timescale 1ns/1ps
module flash_aux_host (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  input  wire flash_aux_pkg::req_t  req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  output logic                      resp_valid,
  output logic [7:0]                resp_data,
  output logic                      sleeping,
  output logic                      id_mode,
  output logic [18:0]               addr_out,
  output logic [7:0]                dq_out,
  output logic                      dq_oe,
  input  wire logic [7:0]           dq_in,
  output logic                      chip_en_n,
  output logic                      out_en_n,
  output logic                      write_en_n
);
  import flash_aux_pkg::*;

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_UNL1  = 3'b001,
    S_UNL2  = 3'b011,
    S_CMD   = 3'b010,
    S_WAIT  = 3'b110,
    S_READ  = 3'b111,
    S_DONE  = 3'b101
  } state_t;

  state_t            st_r;
  state_t            st_nxt;
  req_t              req_r;
  logic [CNT_W-1:0]  wait_r;
  logic              long_wait_r;
  logic              issued_r;
  bus_cycle_t        cyc;
  logic              cyc_valid;
  logic              cyc_ready;
  logic              cyc_done;
  logic [7:0]        rd_data;

  function automatic logic [18:0] id_addr(input req_t r);
    logic [18:0] a;
    a = r.addr & 19'h70000;
    case (r.op)
      OP_MAKER: a = ID_MAKER_OFS;
      OP_PART:  a = ID_PART_OFS;
      OP_LOCK:  a = a | ID_LOCK_OFS;
      default:  a = r.addr;
    endcase
    return a;
  endfunction : id_addr

  wire is_read   = (req_r.op == OP_MAKER) || (req_r.op == OP_PART) ||
                   (req_r.op == OP_LOCK)  || (req_r.op == OP_ARRAY_READ);
  wire needs_unl = (req_r.op == OP_IDENTITY) ||
                   ((req_r.op == OP_RESET) && req_r.with_unlock);
  // A read while asleep is refused in favour of a reset first.
  wire blocked   = sleeping && (req.op != OP_RESET);
  wire wait_zero = (wait_r == '0);
  wire [7:0] cmd_byte = (req_r.op == OP_IDENTITY) ? READ_IDENTITY_CMD :
                        (req_r.op == OP_SLEEP)    ? SLEEP_CMD : RESET_CMD;

  assign req_ready = (st_r == S_IDLE) && !blocked;

  always_comb begin
    cyc = '0;
    cyc_valid = 1'b0;
    case (st_r)
      S_UNL1: begin
        cyc = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1, we: 1'b1};
        cyc_valid = !issued_r;
      end
      S_UNL2: begin
        cyc = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2, we: 1'b1};
        cyc_valid = !issued_r;
      end
      S_CMD: begin
        cyc = '{addr: UNLOCK_ADDR1, data: cmd_byte, we: 1'b1};
        cyc_valid = !issued_r;
      end
      S_READ: begin
        cyc = '{addr: id_addr(req_r), data: 8'h00, we: 1'b0};
        cyc_valid = !issued_r;
      end
      default: ;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (req_valid && !blocked)
        st_nxt = (req.op == OP_MAKER || req.op == OP_PART ||
                  req.op == OP_LOCK || req.op == OP_ARRAY_READ) ? S_READ :
                 ((req.op == OP_IDENTITY) ||
                  (req.op == OP_RESET && req.with_unlock)) ? S_UNL1 : S_CMD;
      S_UNL1:  if (cyc_done) st_nxt = S_UNL2;
      S_UNL2:  if (cyc_done) st_nxt = S_CMD;
      S_CMD:   if (cyc_done) st_nxt = S_WAIT;
      S_WAIT:  if (wait_zero) st_nxt = S_DONE;
      S_READ:  if (cyc_done) st_nxt = S_DONE;
      S_DONE:  st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // ************************************************************
  // State and mode tracking
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r        <= S_IDLE;
      req_r       <= '0;
      wait_r      <= '0;
      long_wait_r <= 1'b0;
      issued_r    <= 1'b0;
      sleeping    <= 1'b0;
      id_mode     <= 1'b0;
      resp_valid  <= 1'b0;
      resp_data   <= '0;
    end else if (clk_en) begin
      st_r       <= st_nxt;
      resp_valid <= 1'b0;
      if (cyc_valid && cyc_ready) issued_r <= 1'b1;
      if (cyc_done) issued_r <= 1'b0;
      if (st_r == S_IDLE && req_valid && !blocked) begin
        req_r <= req;
        // Unknown state of erase is assumed, so every reset waits.
        long_wait_r <= (req.op == OP_RESET);
      end
      if (st_r == S_CMD && cyc_done) begin
        wait_r <= long_wait_r ? CNT_W'(RESET_WAIT_CYC - 1) : '0;
        case (req_r.op)
          OP_RESET: begin
            sleeping <= 1'b0;
            id_mode  <= 1'b0;
          end
          OP_IDENTITY: id_mode  <= 1'b1;
          OP_SLEEP:    sleeping <= 1'b1;
          default: ;
        endcase
      end
      if (st_r == S_WAIT && !wait_zero) wait_r <= wait_r - 1'b1;
      if (st_r == S_READ && cyc_done) begin
        resp_valid <= 1'b1;
        // Protection byte is compared exactly; only 01h means locked, any other value reads as 00h.
        resp_data  <= (req_r.op == OP_LOCK) ?
                      ((rd_data == LOCK_SET) ? LOCK_SET : LOCK_CLEAR) :
                      rd_data;
      end
      if (st_r == S_WAIT && wait_zero) resp_valid <= 1'b1;
    end
  end

  flash_bus_cycle u_cyc (
    .clock      (clock),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .cyc        (cyc),
    .cyc_valid  (cyc_valid),
    .cyc_ready  (cyc_ready),
    .cyc_done   (cyc_done),
    .rd_data    (rd_data),
    .addr_out   (addr_out),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in),
    .chip_en_n  (chip_en_n),
    .out_en_n   (out_en_n),
    .write_en_n (write_en_n)
  );

endmodule : flash_aux_host

//--- verification/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
  import flash_aux_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value.
  parameter logic [7:0] PART  = 8'h5a, // Arbitrary value.
  parameter logic [7:0] LOCKS = 8'h00
) (
  input  wire logic        chip_en_n,
  input  wire logic        out_en_n,
  input  wire logic        write_en_n,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq,
  output logic [7:0]       q
);
  // ******
  // Command decoder
  // ******
  logic [18:0] a_r;
  logic [1:0]  seq_r = 2'h0;
  logic        id_r = 1'b0;
  logic        sleep_r = 1'b0;
  logic        fail_r = 1'b1;
  logic [7:0]  last_r = 8'h00;
  logic [7:0]  rd;
  // Chip enable falls in the same step as the strobe, so it is not tested.
  always @(negedge write_en_n) a_r = addr;
  always @(posedge write_en_n) if (!chip_en_n) begin
    if (dq == RESET_CMD) begin
      {id_r, sleep_r, fail_r, seq_r} = '0;
    end else if (!sleep_r) begin
      if (dq == UNLOCK_DATA1 && a_r == UNLOCK_ADDR1) seq_r = 2'h1;
      else if (dq == UNLOCK_DATA2 && a_r == UNLOCK_ADDR2 && seq_r == 2'h1)
        seq_r = 2'h2;
      else begin
        id_r = seq_r == 2'h2 && dq == READ_IDENTITY_CMD
               && a_r == UNLOCK_ADDR1;
        sleep_r = dq == SLEEP_CMD;
        seq_r = 2'h0;
      end
    end
  end
  assign rd = !id_r ? {addr[7:6], fail_r, addr[4:0]} :
              addr[6] ? 8'h00 :
              addr[1:0] == 2'h0 ? MAKER :
              addr[1:0] == 2'h1 ? PART :
              addr[1:0] == 2'h2 ? {7'h0, LOCKS[addr[18:16]]} : 8'h00;
  // A released bus shows the inverse of its last value, never a stale copy.
  assign q = (!chip_en_n && !out_en_n && !sleep_r) ? rd : ~last_r;
  always @(posedge out_en_n) last_r = rd;
endmodule : flash_dev_model

//--- verification/flash_aux_host_sva.sv
`timescale 1ns/1ps
module flash_aux_host_sva
  import flash_aux_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire req_t        req,
  input wire logic        req_ready,
  input wire logic        sleeping,
  input wire logic        id_mode,
  input wire logic [18:0] addr_out,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe,
  input wire logic        chip_en_n,
  input wire logic        out_en_n,
  input wire logic        write_en_n
);
  // ******
  // Last two completed writes and the read hold-off count
  // ******
  logic        we_q;
  logic [26:0] last_r;
  logic [26:0] prev_r;
  logic [9:0]  wait_r;
  wire         wr_end = write_en_n && !we_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {we_q, last_r, prev_r, wait_r} <= {1'b1, 64'h0};
    end else begin
      we_q <= write_en_n;
      if (wr_end) {prev_r, last_r} <= {last_r, addr_out, dq_out};
      if (wr_end && dq_out == RESET_CMD) wait_r <= 10'd500;
      else if (wait_r != 10'h0) wait_r <= wait_r - 10'h1;
    end
  end
  sequence s_we_start; $fell(write_en_n) ##0 !chip_en_n; endsequence
  AST_WE_PULSE: assert property (s_we_start |-> !write_en_n[*6] ##1 write_en_n)
    else $error("write strobe width wrong");
  AST_REFUSE: assert property (sleeping && req.op != OP_RESET |-> !req_ready)
    else $error("request accepted while sleeping");
  AST_ID_ENTRY: assert property ($rose(id_mode) |-> last_r == {UNLOCK_ADDR1,
    READ_IDENTITY_CMD} && prev_r[7:0] == UNLOCK_DATA2)
    else $error("identity mode without its command");
  AST_UNLOCK: assert property (wr_end && dq_out == UNLOCK_DATA2 |->
    addr_out == UNLOCK_ADDR2 && last_r == {UNLOCK_ADDR1, UNLOCK_DATA1})
    else $error("unlock cycles out of order");
  AST_RESET_CLR: assert property ($fell(id_mode) || $fell(sleeping) |->
    ##[0:20] last_r[7:0] == RESET_CMD)
    else $error("mode left without reset command");
  AST_SLEEP: assert property ($rose(sleeping) |->
    ##[0:20] last_r[7:0] == SLEEP_CMD)
    else $error("sleep flag without sleep command");
  AST_READ_WAIT: assert property ($fell(out_en_n) |-> wait_r == 10'h0)
    else $error("read too soon after reset");
  AST_NO_CLASH: assert property (!out_en_n |-> !dq_oe && write_en_n)
    else $error("read overlaps a driven write");
endmodule : flash_aux_host_sva
bind flash_aux_host flash_aux_host_sva chk_u (.clock, .rstn, .req, .req_ready,
  .sleeping, .id_mode, .addr_out, .dq_out, .dq_oe, .chip_en_n, .out_en_n,
  .write_en_n);

//--- verification/flash_aux_host_test.sv
`timescale 1ns/1ps
module flash_aux_host_test;
  import flash_aux_pkg::*;
  // ******
  // Harness
  // ******
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
  localparam logic [7:0] PART  = 8'h5a; // Arbitrary value.
  localparam logic [7:0] LOCKS = 8'h96;
  logic clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, req_valid = 1'b0;
  req_t req = '0;
  logic req_ready, resp_valid, sleeping, id_mode, dq_oe;
  logic chip_en_n, out_en_n, write_en_n;
  logic [7:0] resp_data, dq_out, dq_in, dev_q;
  logic [18:0] addr_out;
  int n_fail = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  assign dq_in = dq_oe ? dq_out : dev_q;
  flash_aux_host dut_u (.clock(clock), .rstn(rstn), .clk_en(clk_en),
    .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .sleeping(sleeping),
    .id_mode(id_mode), .addr_out(addr_out), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .LOCKS(LOCKS)) dev_u (
    .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .addr(addr_out), .dq(dq_in), .q(dev_q));
  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic run_op(input op_t op, input logic [18:0] a, input logic u);
    int i;
    @(negedge clock);
    req = '{op: op, addr: a, with_unlock: u};
    req_valid = 1'b1;
    for (i = 0; i < 2000 && req_ready !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    for (i = i; i < 2000 && resp_valid !== 1'b1; i++) @(negedge clock);
    if (i >= 2000) begin
      chk("handshake timeout", 8'h01, 8'h00);
      close_out();
    end
    @(negedge clock);
  endtask : run_op
  // ******
  // Scenarios
  // ******
  task automatic t_reset_forms;
    run_op(OP_ARRAY_READ, 19'h000ff, 1'b0);
    chk("array before reset", 8'hff, resp_data);
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b1);
    run_op(OP_ARRAY_READ, 19'h000ff, 1'b0);
    chk("array after reset", 8'hdf, resp_data);
    run_op(OP_IDENTITY, UNLOCK_ADDR1, 1'b1);
    chk("id mode set", 8'h01, {7'h0, id_mode});
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b0);
    chk("id mode plain reset", 8'h00, {7'h0, id_mode});
    run_op(OP_IDENTITY, UNLOCK_ADDR1, 1'b1);
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b1);
    chk("id mode unlock reset", 8'h00, {7'h0, id_mode});
  endtask : t_reset_forms
  task automatic t_ident;
    int b;
    run_op(OP_IDENTITY, UNLOCK_ADDR1, 1'b1);
    run_op(OP_MAKER, 19'h0, 1'b0);
    chk("maker code", MAKER, resp_data);
    run_op(OP_PART, 19'h0, 1'b0);
    chk("part code", PART, resp_data);
    for (b = 0; b < 8; b++) begin
      run_op(OP_LOCK, {b[2:0], 16'h0000}, 1'b0);
      chk("block lock", {7'h0, LOCKS[b]}, resp_data);
    end
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b0);
  endtask : t_ident
  task automatic t_freeze;
    @(negedge clock);
    clk_en = 1'b0;
    req = '{op: OP_MAKER, addr: 19'h0, with_unlock: 1'b0};
    req_valid = 1'b1;
    repeat (5) @(negedge clock);
    chk("frozen chip enable", 8'h01, {7'h0, chip_en_n});
    chk("frozen response", 8'h00, {7'h0, resp_valid});
    req_valid = 1'b0;
    clk_en = 1'b1;
    run_op(OP_ARRAY_READ, 19'h00021, 1'b0);
    chk("array after freeze", 8'h01, resp_data);
  endtask : t_freeze
  task automatic t_mid_reset;
    run_op(OP_IDENTITY, UNLOCK_ADDR1, 1'b1);
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    chk("id mode after rstn", 8'h00, {7'h0, id_mode});
    chk("chip enable after rstn", 8'h01, {7'h0, chip_en_n});
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b0);
    run_op(OP_ARRAY_READ, 19'h000ff, 1'b0);
    chk("array after rstn", 8'hdf, resp_data);
  endtask : t_mid_reset
  task automatic t_sleep;
    run_op(OP_SLEEP, UNLOCK_ADDR1, 1'b0);
    chk("sleep flag set", 8'h01, {7'h0, sleeping});
    req = '{op: OP_MAKER, addr: 19'h0, with_unlock: 1'b0};
    @(negedge clock);
    chk("refused while asleep", 8'h00, {7'h0, req_ready});
    run_op(OP_RESET, UNLOCK_ADDR1, 1'b0);
    chk("sleep flag clear", 8'h00, {7'h0, sleeping});
    run_op(OP_ARRAY_READ, 19'h0005a, 1'b0);
    chk("array after wake", 8'h5a, resp_data);
  endtask : t_sleep
  initial begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    t_reset_forms();
    t_freeze();
    t_mid_reset();
    t_ident();
    t_sleep();
    close_out();
  end
endmodule : flash_aux_host_test
